// >>> common/switch_timing_pkg.sv
/*
 Constants shared by the switch timing supervisor: clock rate, timing figures and
 the cycle counts derived from them, and bit positions of the SPI control and status words.
 Assumes a 25 MHz supervisor clock.
*/
package switch_timing_pkg;
	localparam int CLK_MHZ = 25;
	localparam int CLK_KHZ = 25000;
	localparam int CLK_HZ = 25000000;

	localparam int CNT_W = 23;
	localparam int CAL_W = 12;
	localparam int RST_W = 9;
	localparam int MON_W = 12;
	localparam int FRAME_BITS = 16;
	localparam int BIT_W = 4;

	// Timing figures in their own units
	localparam int WDOG_TIMEOUT_MS = 310;
	localparam int RETRY_00_US = 150000;
	localparam int RETRY_01_US = 75000;
	localparam int RETRY_10_US = 37500;
	localparam int RETRY_11_US = 17700;
	localparam int DIRIN_LOW_MS = 250;
	localparam int CAL_MIN_NS = 1500;
	localparam int CAL_MAX_US = 100;
	localparam int RST_LOW_US = 10;
	localparam int EXT_MAX_KHZ = 730;
	localparam int EXT_MIN_HZ = 7000;

	// Derived cycle counts; the calibration minimum rounds up, both external clock periods round down
	localparam int WDOG_CYC = WDOG_TIMEOUT_MS * CLK_KHZ;
	localparam int RETRY_00_CYC = RETRY_00_US * CLK_MHZ;
	localparam int RETRY_01_CYC = RETRY_01_US * CLK_MHZ;
	localparam int RETRY_10_CYC = RETRY_10_US * CLK_MHZ;
	localparam int RETRY_11_CYC = RETRY_11_US * CLK_MHZ;
	localparam int DIRIN_CYC = DIRIN_LOW_MS * CLK_KHZ;
	localparam int CAL_MIN_CYC = (CAL_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int CAL_MAX_CYC = CAL_MAX_US * CLK_MHZ;
	localparam int RST_LOW_CYC = (RST_LOW_US * CLK_MHZ > 0) ? RST_LOW_US * CLK_MHZ : 1;
	localparam int EXT_FAST_CYC = CLK_KHZ / EXT_MAX_KHZ;
	localparam int EXT_SLOW_CYC = CLK_HZ / EXT_MIN_HZ;

	// Control word received over SPI
	localparam int CFG_WATCHDOG_DISABLE_BIT = 0;
	localparam int CFG_RETRY_LO = 1;
	localparam int CFG_RETRY_EN = 3;
	localparam int CFG_CH_ON_LO = 4;
	localparam int CFG_DIRECT = 6;
	localparam int CFG_EXTCLK = 7;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// Status word returned over SPI
	localparam int ST_FAILSAFE = 0;
	localparam int ST_CLKFAIL = 1;
	localparam int ST_FAST = 2;
	localparam int ST_SLOW = 3;
	localparam int ST_FLT_LO = 4;
	localparam int ST_CAL = 6;
	localparam int ST_SLEEP = 7;
	localparam int ST_WDDIS = 8;
	localparam int ST_FAULTLINE = 9;
endpackage

// >>> core/spi_link.sv
/*
 SPI slave shifter on the serial clock: 16-bit frames, MSB first, input sampled on the
 falling edge, output updated on the rising edge. Assumes the transmit word is held
 stable by the supervisor domain while chip select is low.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_link
	import switch_timing_pkg::*;
(
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic chipSelectN,
	input wire logic serialIn,
	input wire logic [FRAME_BITS-1:0] txWord,
	output logic serialOut,
	output logic serialOutEn,
	output logic [FRAME_BITS-1:0] rxWord,
	output logic frameToggle
);
	typedef struct packed {
		logic [BIT_W-1:0] cnt;
		logic [FRAME_BITS-1:0] shift;
	} fall_s;
	typedef struct packed {
		logic [FRAME_BITS-1:0] word;
		logic tgl;
	} hold_s;

	fall_s fall, next_fall;
	hold_s hold, next_hold;
	logic [BIT_W-1:0] soPos;
	wire logic linkClr_n;

	// Bit position restarts whenever the device is deselected
	assign linkClr_n = rst_n & ~chipSelectN;

	always_comb begin
		next_fall.cnt = BIT_W'(fall.cnt + 1'b1);
		next_fall.shift = {fall.shift[FRAME_BITS-2:0], serialIn};
		next_hold = hold;
		if (fall.cnt == BIT_W'(FRAME_BITS - 1)) begin
			next_hold.word = {fall.shift[FRAME_BITS-2:0], serialIn};
			next_hold.tgl = ~hold.tgl;
		end
	end

	always_ff @(negedge sclk or negedge linkClr_n) begin
		if (!linkClr_n)
			fall <= '0;
		else
			fall <= next_fall;
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n)
			hold <= '0;
		else
			hold <= next_hold;
	end

	always_ff @(posedge sclk or negedge linkClr_n) begin
		if (!linkClr_n)
			soPos <= '0;
		else
			soPos <= fall.cnt;
	end

	assign serialOut = txWord[~soPos];
	assign serialOutEn = ~chipSelectN;
	assign rxWord = hold.word;
	assign frameToggle = hold.tgl;
endmodule // spi_link
`default_nettype wire

// >>> core/ext_clock_monitor.sv
/*
 Frequency monitor for the external PWM clock: measures supervisor cycles between rising
 edges and flags a clock that runs too fast or too slow or is absent.
 Assumes the external clock is asynchronous to mclk and far slower.
*/
`timescale 1ns/100ps
`default_nettype none
module ext_clock_monitor
	import switch_timing_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic extClk,
	output logic tooFast,
	output logic tooSlow
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic primed;
		logic [MON_W-1:0] cnt;
		logic fast;
		logic slow;
	} mon_s;

	mon_s st, next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = extClk;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.cnt != '1)
			next_st.cnt = MON_W'(st.cnt + 1'b1);
		if (!enable) begin
			next_st.primed = 1'b0;
			next_st.cnt = '0;
			next_st.fast = 1'b0;
			next_st.slow = 1'b0;
		end else if (st.s2 && !st.s3) begin
			next_st.cnt = MON_W'(1);
			next_st.primed = 1'b1;
			next_st.slow = 1'b0;
			next_st.fast = st.primed && (st.cnt < MON_W'(EXT_FAST_CYC));
		end else if (st.cnt >= MON_W'(EXT_SLOW_CYC)) begin
			next_st.slow = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign tooFast = st.fast;
	assign tooSlow = st.slow;
endmodule // ext_clock_monitor
`default_nettype wire

// >>> core/switch_timing_supervisor.sv
/*
 Timing supervisor of a dual high side switch: SPI-loss watchdog with fail-safe entry,
 auto-retry timer, direct-input long-low detection, chip-select calibration pulse
 detection, reset-pin handling and external clock fault reporting.
 Assumes an SPI master on its own clock and channel fault inputs from protection logic.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - Fail-safe after watchdog timeout without SPI contact
// - Watchdog runs only while disable bit clear
// - Timeout measured from reset pin rising edge
// - Retry period 150 ms or 75 ms
// - Retry period 37.5 ms or 17.7 ms
// - Calibration pulse at least minimum low time
// - Calibration pulse at most maximum low time
// - Flag external clock above upper threshold
// - Flag external clock below lower threshold
// - Long direct input low delatches or sleeps
// - Serial input sampled on falling clock edge
// - Serial output updated after rising clock edge
// - Serial output driven only while selected
// - Fault flag pulled low on any fault
// - Reset pin low switches off SPI channels
module switch_timing_supervisor
	import switch_timing_pkg::*;
#(
	parameter logic [CNT_W-1:0] WDOG_CYCLES = CNT_W'(WDOG_CYC),
	parameter logic [CNT_W-1:0] RETRY_00_CYCLES = CNT_W'(RETRY_00_CYC),
	parameter logic [CNT_W-1:0] RETRY_01_CYCLES = CNT_W'(RETRY_01_CYC),
	parameter logic [CNT_W-1:0] RETRY_10_CYCLES = CNT_W'(RETRY_10_CYC),
	parameter logic [CNT_W-1:0] RETRY_11_CYCLES = CNT_W'(RETRY_11_CYC),
	parameter logic [CNT_W-1:0] DIRIN_CYCLES = CNT_W'(DIRIN_CYC)
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic chipSelectN,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	input wire logic resetNInput,
	input wire logic [1:0] directIn,
	input wire logic [1:0] chanFault,
	input wire logic extClk,
	input wire logic faultFlagNIn,
	output logic faultFlagNOut,
	output logic faultFlagNOe,
	output logic [1:0] highSideOutputs,
	output logic failSafe,
	output logic sleepReq,
	output logic calStrobe
);
	typedef struct packed {
		logic rstS1;
		logic rstS2;
		logic csS1;
		logic csS2;
		logic csS3;
		logic [1:0] dirS1;
		logic [1:0] dirS2;
		logic fltS1;
		logic fltS2;
		logic tglS1;
		logic tglS2;
		logic tglS3;
		logic [FRAME_BITS-1:0] cfg;
		logic [FRAME_BITS-1:0] txWord;
		logic [CNT_W-1:0] wdCnt;
		logic failSafe;
		logic [RST_W-1:0] rstLowCnt;
		logic [CAL_W-1:0] calCnt;
		logic calFrame;
		logic calStrobe;
		logic calDone;
		logic [CNT_W-1:0] retryCnt;
		logic [1:0] faultLatch;
		logic [1:0][CNT_W-1:0] dirCnt;
		logic sleepReq;
		logic clockFail;
		logic [1:0] hs;
		logic fsbOe;
	} state_s;

	state_s st, next_st;
	logic [FRAME_BITS-1:0] rxWord;
	logic frameToggle;
	logic tooFast;
	logic tooSlow;

	function automatic logic [CNT_W-1:0] incSat(input logic [CNT_W-1:0] v,
			input logic [CNT_W-1:0] limit);
		incSat = (v >= limit) ? limit : CNT_W'(v + 1'b1);
	endfunction

	function automatic logic [CNT_W-1:0] retryPeriod(input logic [1:0] sel);
		unique case (sel)
			2'b00: retryPeriod = RETRY_00_CYCLES;
			2'b01: retryPeriod = RETRY_01_CYCLES;
			2'b10: retryPeriod = RETRY_10_CYCLES;
			2'b11: retryPeriod = RETRY_11_CYCLES;
		endcase
	endfunction

	spi_link u_link (
		.rst_n(rst_n),
		.sclk(sclk),
		.chipSelectN(chipSelectN),
		.serialIn(serialIn),
		.txWord(st.txWord),
		.serialOut(serialOut),
		.serialOutEn(serialOutEn),
		.rxWord(rxWord),
		.frameToggle(frameToggle)
	);

	ext_clock_monitor u_mon (
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(st.cfg[CFG_EXTCLK]),
		.extClk(extClk),
		.tooFast(tooFast),
		.tooSlow(tooSlow)
	);

	always_comb begin
		logic frame;
		logic rstLow;
		logic csRise;
		logic retryHit;
		logic [1:0] clearFlt;
		logic [1:0] dirLong;
		logic [1:0] chanReq;
		logic directMode;
		frame = 1'b0;
		rstLow = 1'b0;
		csRise = 1'b0;
		retryHit = 1'b0;
		clearFlt = 2'b00;
		dirLong = 2'b00;
		chanReq = 2'b00;
		directMode = 1'b0;
		next_st = st;

		// Pin synchronisers
		next_st.rstS1 = resetNInput;
		next_st.rstS2 = st.rstS1;
		next_st.csS1 = chipSelectN;
		next_st.csS2 = st.csS1;
		next_st.csS3 = st.csS2;
		next_st.dirS1 = directIn;
		next_st.dirS2 = st.dirS1;
		next_st.fltS1 = faultFlagNIn;
		next_st.fltS2 = st.fltS1;
		next_st.tglS1 = frameToggle;
		next_st.tglS2 = st.tglS1;
		next_st.tglS3 = st.tglS2;

		// Received word is stable for a full frame plus the deselect gap
		frame = st.tglS2 ^ st.tglS3;
		if (frame)
			next_st.cfg = rxWord;

		// Reset pin held low long enough clears the SPI configuration
		if (!st.rstS2) begin
			if (st.rstLowCnt != RST_W'(RST_LOW_CYC))
				next_st.rstLowCnt = RST_W'(st.rstLowCnt + 1'b1);
			else
				rstLow = 1'b1;
		end else begin
			next_st.rstLowCnt = '0;
		end
		if (rstLow)
			next_st.cfg = CFG_RESET;

		// SPI-loss watchdog, cleared while the reset pin is low
		if (!st.rstS2 || frame || st.cfg[CFG_WATCHDOG_DISABLE_BIT]) begin
			next_st.wdCnt = '0;
		end else if (!st.failSafe) begin
			next_st.wdCnt = incSat(st.wdCnt, WDOG_CYCLES);
			if (st.wdCnt == CNT_W'(WDOG_CYCLES - 1'b1))
				next_st.failSafe = 1'b1;
		end
		if (rstLow || frame)
			next_st.failSafe = 1'b0;

		// Calibration: a select low pulse with no frame inside it
		csRise = st.csS2 && !st.csS3;
		if (!st.csS2) begin
			if (st.calCnt != CAL_W'(CAL_MAX_CYC + 1))
				next_st.calCnt = CAL_W'(st.calCnt + 1'b1);
			if (frame)
				next_st.calFrame = 1'b1;
		end
		next_st.calStrobe = 1'b0;
		if (csRise) begin
			next_st.calCnt = '0;
			next_st.calFrame = 1'b0;
			if (!st.calFrame && !frame && st.calCnt >= CAL_W'(CAL_MIN_CYC)
					&& st.calCnt <= CAL_W'(CAL_MAX_CYC)) begin
				next_st.calStrobe = 1'b1;
				next_st.calDone = 1'b1;
			end
		end

		// Auto-retry repetition timer
		if (st.cfg[CFG_RETRY_EN] && (|st.faultLatch)) begin
			if (st.retryCnt >= CNT_W'(retryPeriod(st.cfg[CFG_RETRY_LO +: 2]) - 1'b1)) begin
				retryHit = 1'b1;
				next_st.retryCnt = '0;
			end else begin
				next_st.retryCnt = CNT_W'(st.retryCnt + 1'b1);
			end
		end else begin
			next_st.retryCnt = '0;
		end

		// Long low on a direct input delatches the channel
		directMode = st.cfg[CFG_DIRECT] || st.failSafe;
		for (int i = 0; i < 2; i++) begin
			if (directMode && !st.dirS2[i]) begin
				next_st.dirCnt[i] = incSat(st.dirCnt[i], DIRIN_CYCLES);
				if (st.dirCnt[i] == CNT_W'(DIRIN_CYCLES - 1'b1))
					clearFlt[i] = 1'b1;
				dirLong[i] = (st.dirCnt[i] == DIRIN_CYCLES);
			end else begin
				next_st.dirCnt[i] = '0;
			end
		end
		next_st.sleepReq = &dirLong;

		// Channel fault latches; a new fault wins over its clear
		clearFlt = clearFlt | {2{retryHit}};
		next_st.faultLatch = (st.faultLatch & ~clearFlt) | chanFault;

		// Clock failure flag, cleared by the next frame unless still failing
		next_st.clockFail = (st.clockFail && !frame) || tooFast || tooSlow;

		chanReq = directMode ? st.dirS2 : st.cfg[CFG_CH_ON_LO +: 2];
		next_st.hs = chanReq & ~st.faultLatch;
		next_st.fsbOe = st.clockFail || (|st.faultLatch);

		// Status word frozen while selected so the shifter sees a stable value
		if (st.csS2) begin
			next_st.txWord = '0;
			next_st.txWord[ST_FAILSAFE] = st.failSafe;
			next_st.txWord[ST_CLKFAIL] = st.clockFail;
			next_st.txWord[ST_FAST] = tooFast;
			next_st.txWord[ST_SLOW] = tooSlow;
			next_st.txWord[ST_FLT_LO +: 2] = st.faultLatch;
			next_st.txWord[ST_CAL] = st.calDone;
			next_st.txWord[ST_SLEEP] = st.sleepReq;
			next_st.txWord[ST_WDDIS] = st.cfg[CFG_WATCHDOG_DISABLE_BIT];
			next_st.txWord[ST_FAULTLINE] = ~st.fltS2;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.rstS1 <= 1'b1;
			st.rstS2 <= 1'b1;
			st.csS1 <= 1'b1;
			st.csS2 <= 1'b1;
			st.csS3 <= 1'b1;
			st.fltS1 <= 1'b1;
			st.fltS2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign faultFlagNOut = 1'b0;
	assign faultFlagNOe = st.fsbOe;
	assign highSideOutputs = st.hs;
	assign failSafe = st.failSafe;
	assign sleepReq = st.sleepReq;
	assign calStrobe = st.calStrobe;
endmodule // switch_timing_supervisor
`default_nettype wire

// >>> dv/sts_monitor.sv
/*
 Assertion checker for the switch timing supervisor, bound to its top module.
 Assumes every watched output except serialOutEn and faultFlagNOut is clocked by mclk and cleared by rst_n.
*/
`timescale 1ns/100ps
`default_nettype none
module sts_monitor
	import switch_timing_pkg::*;
#(
	parameter logic [CNT_W-1:0] WDOG_CYCLES = CNT_W'(WDOG_CYC),
	parameter logic [CNT_W-1:0] DIRIN_CYCLES = CNT_W'(DIRIN_CYC)
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic chipSelectN,
	input wire logic serialOutEn,
	input wire logic resetNInput,
	input wire logic [1:0] directIn,
	input wire logic [1:0] chanFault,
	input wire logic faultFlagNOut,
	input wire logic faultFlagNOe,
	input wire logic [1:0] highSideOutputs,
	input wire logic failSafe,
	input wire logic sleepReq,
	input wire logic calStrobe
);
	logic [CNT_W-1:0] pinCnt;
	logic [CNT_W-1:0] dirCnt;
	logic [CAL_W:0] csCnt;
	logic [CAL_W:0] lastLow;
	logic [RST_W:0] rstCnt;

	// Saturating cycle counts of the pin and input levels; wrapping count of the select level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinCnt <= '0;
			dirCnt <= '0;
			csCnt <= '0;
			lastLow <= '0;
			rstCnt <= '0;
		end else begin
			pinCnt <= !resetNInput ? '0 : pinCnt + CNT_W'(pinCnt != '1);
			dirCnt <= (directIn != 2'h0) ? '0 : dirCnt + CNT_W'(dirCnt != '1);
			rstCnt <= resetNInput ? '0 : rstCnt + (RST_W + 1)'(rstCnt != '1);
			csCnt <= chipSelectN ? '0 : csCnt + 1'h1;
			if (chipSelectN && csCnt != '0)
				lastLow <= csCnt;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	oe_follows_cs_a: assert property (serialOutEn == !chipSelectN)
		else $error("Output enable does not follow select");
	open_drain_a: assert property (faultFlagNOut == 1'h0)
		else $error("Fault line driven high");
	fault_pulls_a: assert property ($rose(chanFault[0]) |-> ##[1:3] faultFlagNOe)
		else $error("Fault line not pulled low");
	pin_clear_a: assert property (rstCnt >= 260 |-> highSideOutputs == 2'h0 && !failSafe)
		else $error("Outputs on while reset pin held");
	wd_not_early_a: assert property ($rose(failSafe) |-> pinCnt >= WDOG_CYCLES)
		else $error("Fail-safe entered early");
	cal_window_a: assert property (calStrobe |-> lastLow >= 37 && lastLow <= 2501)
		else $error("Calibration accepted outside window");
	cal_single_a: assert property (calStrobe |-> chipSelectN ##1 !calStrobe)
		else $error("Calibration strobe malformed");
	sleep_not_early_a: assert property ($rose(sleepReq) |-> dirCnt >= DIRIN_CYCLES)
		else $error("Sleep requested early");

	cover property ($rose(failSafe));
	cover property (calStrobe);
	cover property ($rose(sleepReq));
endmodule // sts_monitor

bind switch_timing_supervisor sts_monitor #(
	.WDOG_CYCLES(WDOG_CYCLES),
	.DIRIN_CYCLES(DIRIN_CYCLES)
) mon (
	.mclk(mclk), .rst_n(rst_n), .chipSelectN(chipSelectN), .serialOutEn(serialOutEn),
	.resetNInput(resetNInput), .directIn(directIn), .chanFault(chanFault),
	.faultFlagNOut(faultFlagNOut), .faultFlagNOe(faultFlagNOe),
	.highSideOutputs(highSideOutputs), .failSafe(failSafe), .sleepReq(sleepReq),
	.calStrobe(calStrobe)
);
`default_nettype wire

// >>> dv/spi_host_model.sv
/*
 SPI host model: 16-bit frames MSB first and calibration pulses on select.
 Assumes the caller keeps the reset-pin setup time before the first frame.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	output logic sclk,
	output logic chipSelectN,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	initial begin
		sclk = 1'h0;
		chipSelectN = 1'h1;
		serialIn = 1'h0;
	end

	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		#7;
		chipSelectN = 1'h0;
		#600;
		for (int i = 15; i >= 0; i--) begin
			serialIn = tx[i];
			sclk = 1'h1;
			#32;
			sclk = 1'h0;
			// A released output reads as its pull-up level
			rx[i] = serialOutEn ? serialOut : 1'h1;
			#32;
		end
		#40;
		chipSelectN = 1'h1;
		serialIn = ~serialIn;
		#1000;
	endtask

	task automatic calPulse(input int ns);
		#7;
		chipSelectN = 1'h0;
		#(ns);
		chipSelectN = 1'h1;
		#1000;
	endtask
endmodule // spi_host_model
`default_nettype wire

// >>> dv/tb_top.sv
/*
 Self-checking bench for the switch timing supervisor with an SPI host model.
 Assumes the shortened timing parameters set at the instance below.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic mclk, rst_n, resetNInput, extClk, serialOut, serialOutEn;
	logic faultFlagNOut, faultFlagNOe, failSafe, sleepReq, calStrobe;
	logic [1:0] directIn, chanFault, highSideOutputs;
	logic [15:0] rx;
	wire logic sclk, chipSelectN, serialIn;
	wire logic faultFlagNIn = faultFlagNOe ? faultFlagNOut : 1'h1;
	int n_mismatch, total_checks, cycles, calCount;

	// Shortened timings; retry periods halve with each select code
	localparam logic [22:0] WDOG_T = 23'h7D0;
	localparam logic [22:0] RETRY_T = 23'h190;
	localparam logic [22:0] DIRIN_T = 23'h12C;

	switch_timing_supervisor #(
		.WDOG_CYCLES(WDOG_T), .RETRY_00_CYCLES(RETRY_T), .RETRY_01_CYCLES(RETRY_T >> 1),
		.RETRY_10_CYCLES(RETRY_T >> 2), .RETRY_11_CYCLES(RETRY_T >> 3), .DIRIN_CYCLES(DIRIN_T)
	) dut (
		.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .chipSelectN(chipSelectN),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.resetNInput(resetNInput), .directIn(directIn), .chanFault(chanFault),
		.extClk(extClk), .faultFlagNIn(faultFlagNIn), .faultFlagNOut(faultFlagNOut),
		.faultFlagNOe(faultFlagNOe), .highSideOutputs(highSideOutputs),
		.failSafe(failSafe), .sleepReq(sleepReq), .calStrobe(calStrobe)
	);
	spi_host_model host (.sclk(sclk), .chipSelectN(chipSelectN), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn));

	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (calStrobe === 1'h1)
			calCount++;
		if (cycles == 40000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'h1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic pinPulse();
		cyc(1);
		resetNInput <= 1'h0;
		cyc(262);
		resetNInput <= 1'h1;
		cyc(130);
	endtask

	task automatic t_reset();
		pinPulse();
		host.xfer(16'h0031, rx);
		chk(rx, 16'h0, 16'h0);
		cyc(6);
		chk(highSideOutputs, 2'h3, 2'h3);
		host.xfer(16'h0031, rx);
		chk(rx, 16'h100, 16'h100);
		pinPulse();
		chk(highSideOutputs, 2'h0, 2'h0);
	endtask

	task automatic t_wd();
		int n;
		cyc(1);
		resetNInput <= 1'h0;
		cyc(262);
		resetNInput <= 1'h1;
		n = 0;
		while (failSafe !== 1'h1 && n < 2300) begin
			cyc(1);
			n++;
		end
		chk(n, 2000, 2010);
		host.xfer(16'h0, rx);
		chk(rx[0], 1'h1, 1'h1);
		cyc(6);
		chk(failSafe, 1'h0, 1'h0);
		cyc(1500);
		host.xfer(16'h0, rx);
		cyc(1500);
		chk(failSafe, 1'h0, 1'h0);
		cyc(600);
		chk(failSafe, 1'h1, 1'h1);
		host.xfer(16'h1, rx);
		cyc(2600);
		chk(failSafe, 1'h0, 1'h0);
	endtask

	task automatic faultPulse(input logic [1:0] mask);
		cyc(1);
		chanFault <= mask;
		cyc(1);
		chanFault <= 2'h0;
		cyc(3);
		chk(faultFlagNOe, 1'h1, 1'h1);
	endtask

	task automatic waitOn(output int n);
		n = 0;
		while (highSideOutputs[0] !== 1'h1 && n < 1000) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_retry();
		int n;
		for (int c = 0; c < 4; c++) begin
			host.xfer(16'h19 | 16'(c << 1), rx);
			faultPulse(2'h1);
			waitOn(n);
			faultPulse(2'h3);
			waitOn(n);
			chk(n, (400 >> c) - 6, (400 >> c) + 6);
		end
	endtask

	task automatic t_dir();
		host.xfer(16'h41, rx);
		cyc(1);
		directIn <= 2'h3;
		cyc(5);
		directIn <= 2'h0;
		cyc(280);
		chk(sleepReq, 1'h0, 1'h0);
		cyc(40);
		chk(sleepReq, 1'h1, 1'h1);
		directIn <= 2'h3;
	endtask

	task automatic extRun(input int half, input int n);
		repeat (n) begin
			cyc(half);
			extClk <= ~extClk;
		end
	endtask

	task automatic t_clk();
		host.xfer(16'h81, rx);
		extRun(10, 12);
		host.xfer(16'h81, rx);
		chk(rx[2:1], 2'h3, 2'h3);
		chk(faultFlagNOe, 1'h1, 1'h1);
		extRun(50, 8);
		host.xfer(16'h81, rx);
		extRun(50, 4);
		host.xfer(16'h81, rx);
		chk(rx[2:1], 2'h0, 2'h0);
		cyc(3700);
		host.xfer(16'h1, rx);
		chk({rx[3], rx[1]}, 2'h3, 2'h3);
	endtask

	task automatic t_cal();
		int lens[4] = '{1200, 2000, 60000, 120000};
		int c0;
		logic e;
		for (int i = 0; i < 4; i++) begin
			c0 = calCount;
			e = lens[i] >= 1500 && lens[i] <= 100000;
			host.calPulse(lens[i]);
			cyc(8);
			chk(calCount - c0, e, e);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		rst_n = 1'h0;
		resetNInput = 1'h0;
		directIn = 2'h0;
		chanFault = 2'h0;
		extClk = 1'h0;
		cyc(3);
		rst_n <= 1'h1;
		t_reset();
		t_wd();
		t_retry();
		t_dir();
		t_clk();
		t_cal();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
